// File: inc/bucc_pkg.sv
/*
 package for the bcd up/down counter control block: register map, field
 layouts, reset values, scan timing, tri-level carrier and state encoding.
 assumes a 100 MHz system clock; included before every design file.
*/
package bucc_pkg;

   // register bus geometry and map
   localparam int           ADDR_W       = 8;
   localparam logic [7:0]   REG_STATUS   = 8'h00;
   localparam logic [7:0]   REG_MASK     = 8'h04;
   localparam logic [7:0]   REG_CTRL     = 8'h08;
   localparam logic [7:0]   REG_COUNT    = 8'h0C;
   localparam logic [7:0]   REG_COMPARE  = 8'h10;
   localparam logic [7:0]   REG_LATCH    = 8'h14;

   // event bits of status and mask
   localparam int           EV_MATCH     = 0;
   localparam int           EV_ZERO      = 1;
   localparam int           EV_LOAD      = 2;
   localparam int           EV_W         = 3;
   localparam logic [2:0]   STATUS_RST   = 3'h0;
   localparam logic [2:0]   MASK_RST     = 3'h0;

   // control register: bit 0 selects the external scan source
   localparam int           CTRL_EXT_BIT = 0;
   localparam logic         CTRL_RST     = 1'h0;

   // counter and digit constants
   localparam logic [15:0]  CNT_RST      = 16'h0000;
   localparam logic [15:0]  CMP_RST      = 16'h0000;
   localparam logic [1:0]   MSD          = 2'h3;
   localparam logic [1:0]   LSD          = 2'h0;

   // scan oscillator: digit on time in ns, rounded up to cycles
   localparam int           CLK_PERIOD_NS = 10;
   localparam int           DIGIT_ON_NS   = 2500;
   localparam int           DIGIT_CYCLES  = (DIGIT_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int           DIV_W         = 9;

   // tri-level control indices
   localparam int           TRI_CMP      = 0;
   localparam int           TRI_PRE      = 1;
   localparam int           TRI_SEG      = 2;
   localparam int           TRI_N        = 3;

   // decoded three-level input
   typedef struct packed {
      logic high;
      logic low;
      logic open_c;
   } bucc_tri_t;

   // sequencer states
   typedef enum logic [2:0] {
      ST_NORM = 3'b001,
      ST_LOAD = 3'b010,
      ST_OFF  = 3'b100
   } bucc_state_t;

endpackage

// File: src/bucc_tri_decode.sv
/*
 synchroniser and decoder for one three-level control pin.
 assumes the pad gives two comparator outputs: above-high and below-low.
*/
`timescale 1ns/1ps
module bucc_tri_decode (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // pad comparators
   input  wire logic              pin_hi,
   input  wire logic              pin_lo,
   // decoded level
   output bucc_pkg::bucc_tri_t    level
);
   logic [1:0] meta_q;
   logic [1:0] sync_q;

   // two flops before any decode; first stage feeds only the second
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta_q <= 2'h0;
         sync_q <= 2'h0;
      end else begin
         meta_q <= {pin_hi, pin_lo};
         sync_q <= meta_q;
      end
   end

   // both or neither comparator tripped reads as disconnected
   assign level.high   = sync_q[1] & ~sync_q[0];
   assign level.low    = sync_q[0] & ~sync_q[1];
   assign level.open_c = ~(level.high | level.low);

   tri_onehot_a: assert property (
      @(posedge clk) disable iff (!rst_b) $onehot({level.high, level.low, level.open_c}))
      else $error("tri-level decode not one-hot");

endmodule // bucc_tri_decode

// File: src/bucc_seg_enc.sv
/*
 registered bcd to seven segment encoder with blanking.
 assumes segment order {g,f,e,d,c,b,a}, active high.
*/
`timescale 1ns/1ps
module bucc_seg_enc (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // digit in
   input  wire logic [3:0]  digit,
   input  wire logic        blank,
   // segments out
   output logic      [6:0]  seg_q
);
   logic [6:0] seg_d;

   // every digit lights a or b, so cascaded parts can sense it
   always_comb begin
      case (digit)
         4'h0:    seg_d = 7'h3F;
         4'h1:    seg_d = 7'h06;
         4'h2:    seg_d = 7'h5B;
         4'h3:    seg_d = 7'h4F;
         4'h4:    seg_d = 7'h66;
         4'h5:    seg_d = 7'h6D;
         4'h6:    seg_d = 7'h7D;
         4'h7:    seg_d = 7'h07;
         4'h8:    seg_d = 7'h7F;
         4'h9:    seg_d = 7'h6F;
         default: seg_d = 7'h79; // non-bcd shows E, still lights a
      endcase
   end

   // blanked digit drives nothing
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         seg_q <= 7'h00;
      end else begin
         seg_q <= blank ? 7'h00 : seg_d;
      end
   end

   seg_ab_a: assert property (
      @(posedge clk) disable iff (!rst_b) !blank |=> (seg_q[0] | seg_q[1]))
      else $error("unblanked digit without segment a or b");
   seg_blank_a: assert property (
      @(posedge clk) disable iff (!rst_b) blank |=> (seg_q == 7'h00))
      else $error("blanked digit drives segments");

endmodule // bucc_seg_enc

// File: src/bucc_top.sv
/*
 four-decade bcd up/down counter with compare register, output latch,
 multiplexed display scan, bcd port, flags and a small register file.
 assumes pad-side comparators for tri-level pins and an external tri-state
 resolver for the bcd port; one 100 MHz clock.
*/
//
// Contract
// - three control pins decode high, low, open
// - store low updates latch, else hold
// - direction high or open counts up
// - counter reset low holds counter cleared
// - preset load: open normal, high load, low tristate
// - compare load high loads register only
// - compare load low: display off, scan stopped
// - segment control: high off, low no blanking
// - match flag low when counter equals register
// - unblanked digit lights a or b
// - loading scans from internal oscillator only
// - load msd to lsd, resample, repeat
// - both loads open: bcd out scanned
// - counter reset leaves compare register intact
`timescale 1ns/1ps
module bucc_top (
   // clock and reset
   input  wire logic               SYS_CLK,
   input  wire logic               RST_B,
   // register port
   input  wire logic [7:0]         ADDR,
   input  wire logic [31:0]        WDATA,
   input  wire logic               WR,
   input  wire logic               RD,
   output logic      [31:0]        RDATA,
   output logic                    IRQ,
   // tri-level pins, as comparator pairs
   input  wire logic [2:0]         TRI_HI,
   input  wire logic [2:0]         TRI_LO,
   // plain control pins
   input  wire logic               STORE_B,
   input  wire logic               UP_DN,
   input  wire logic               CNT_RST_B,
   input  wire logic               COUNT_IN,
   input  wire logic               SCAN_EXT,
   // bcd port
   input  wire logic [3:0]         BCD_I,
   output logic      [3:0]         BCD_O,
   output logic      [3:0]         BCD_OE,
   // display and flags
   output logic      [6:0]         SEG_O,
   output logic      [3:0]         DIGIT_O,
   output logic                    MATCH_B,
   output logic                    ZERO_B
);
   bucc_pkg::bucc_tri_t             tri_lv [bucc_pkg::TRI_N];
   bucc_pkg::bucc_state_t           state_q;
   logic [8:0]                      pin_meta_q, pin_sync_q;
   logic                            cnt_prev_q, scan_prev_q;
   logic                            store_s, up_s, crst_b_s, count_s, scan_s;
   logic [bucc_pkg::DIV_W-1:0]      div_q;
   logic [1:0]                      digit_q;
   logic                            ld_cnt_q, ld_reg_q, ext_sel_q;
   logic [15:0]                     cnt_q, cmp_q, latch_q;
   logic [2:0]                      status_q, mask_q, ev;
   logic                            tick, tick_int, load_req, nz, blank;
   logic                            match_now, zero_now, match_prev_q, zero_prev_q;
   logic [3:0]                      load_data, bcd_s;
   // one decoder per tri-level pin
   for (genvar i = 0; i < bucc_pkg::TRI_N; i++) begin : g_tri
      bucc_tri_decode u_tri (
         .clk    (SYS_CLK),
         .rst_b  (RST_B),
         .pin_hi (TRI_HI[i]),
         .pin_lo (TRI_LO[i]),
         .level  (tri_lv[i])
      );
   end
   // pin synchronisers, bcd port too since switches are asynchronous; pulled-up pins idle high
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         pin_meta_q  <= 9'h007;
         pin_sync_q  <= 9'h007;
         cnt_prev_q  <= 1'b0;
         scan_prev_q <= 1'b0;
      end else begin
         pin_meta_q  <= {BCD_I, SCAN_EXT, COUNT_IN, CNT_RST_B, UP_DN, STORE_B};
         pin_sync_q  <= pin_meta_q;
         cnt_prev_q  <= count_s;
         scan_prev_q <= scan_s;
      end
   end
   assign {bcd_s, scan_s, count_s, crst_b_s, up_s, store_s} = pin_sync_q;
   assign load_req = tri_lv[bucc_pkg::TRI_CMP].high | tri_lv[bucc_pkg::TRI_PRE].high;
   // free-running digit oscillator; stopped while display is off
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         div_q <= '0;
      end else if (state_q == bucc_pkg::ST_OFF || (state_q == bucc_pkg::ST_NORM && load_req)) begin
         div_q <= '0;
      end else if (tick_int) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end
   assign tick_int = (div_q == bucc_pkg::DIV_W'(bucc_pkg::DIGIT_CYCLES - 1));
   // external scan only in normal mode; loads keep their own timing
   assign tick = (state_q == bucc_pkg::ST_LOAD || !ext_sel_q) ? tick_int
                 : (scan_s & ~scan_prev_q);
   // sequencer: normal, preset load, display off
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         state_q  <= bucc_pkg::ST_NORM;
         digit_q  <= bucc_pkg::MSD;
         ld_cnt_q <= 1'b0;
         ld_reg_q <= 1'b0;
      end else begin
         case (state_q)
            bucc_pkg::ST_NORM: begin
               if (load_req) begin
                  state_q  <= bucc_pkg::ST_LOAD;
                  digit_q  <= bucc_pkg::MSD;
                  ld_cnt_q <= tri_lv[bucc_pkg::TRI_PRE].high;
                  ld_reg_q <= tri_lv[bucc_pkg::TRI_CMP].high;
               end else if (tri_lv[bucc_pkg::TRI_CMP].low) begin
                  state_q <= bucc_pkg::ST_OFF;
                  digit_q <= bucc_pkg::MSD;
               end else if (tick) begin
                  digit_q <= digit_q - 2'h1;
               end
            end
            bucc_pkg::ST_LOAD: begin
               if (tick) begin
                  digit_q <= digit_q - 2'h1;
                  if (digit_q == bucc_pkg::LSD) begin
                     ld_cnt_q <= tri_lv[bucc_pkg::TRI_PRE].high;
                     ld_reg_q <= tri_lv[bucc_pkg::TRI_CMP].high;
                     if (!load_req) begin
                        state_q <= bucc_pkg::ST_NORM;
                     end
                  end
               end
            end
            bucc_pkg::ST_OFF: begin
               digit_q <= bucc_pkg::MSD;
               if (load_req) begin
                  state_q  <= bucc_pkg::ST_LOAD;
                  ld_cnt_q <= tri_lv[bucc_pkg::TRI_PRE].high;
                  ld_reg_q <= tri_lv[bucc_pkg::TRI_CMP].high;
               end else if (!tri_lv[bucc_pkg::TRI_CMP].low) begin
                  state_q <= bucc_pkg::ST_NORM;
               end
            end
            default: begin
               state_q <= bucc_pkg::ST_NORM;
            end
         endcase
      end
   end
   // bcd step by one, ripple carry or borrow across decades
   function automatic logic [15:0] bcd_step(input logic [15:0] v, input logic up);
      logic [15:0] r;
      logic        c;
      logic [3:0]  n;
      r = v;
      c = 1'b1;
      for (int i = 0; i < 4; i++) begin
         n = v[i*4 +: 4];
         if (c && up) begin
            c = (n == 4'h9);
            n = c ? 4'h0 : n + 4'h1;
         end else if (c) begin
            c = (n == 4'h0);
            n = c ? 4'h9 : n - 4'h1;
         end
         r[i*4 +: 4] = n;
      end
      return r;
   endfunction
   // while counter reset is low a load writes zeros; synced data is stable by the digit's end
   assign load_data = crst_b_s ? bcd_s : 4'h0;
   // counter: reset pin wins, then preset, then count
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         cnt_q <= bucc_pkg::CNT_RST;
      end else if (!crst_b_s) begin
         cnt_q <= bucc_pkg::CNT_RST;
      end else if (state_q == bucc_pkg::ST_LOAD && ld_cnt_q) begin
         // counting is inhibited for the whole preset cycle
         if (tick) begin
            cnt_q[digit_q*4 +: 4] <= load_data;
         end
      end else if (count_s && !cnt_prev_q) begin
         cnt_q <= bcd_step(cnt_q, up_s);
      end
   end
   // compare register; the counter reset pin reaches it only by zeroing the load data
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         cmp_q <= bucc_pkg::CMP_RST;
      end else if (state_q == bucc_pkg::ST_LOAD && ld_reg_q && tick) begin
         cmp_q[digit_q*4 +: 4] <= load_data;
      end
   end
   // output latch follows counter while store is low
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         latch_q <= bucc_pkg::CNT_RST;
      end else if (!store_s) begin
         latch_q <= cnt_q;
      end
   end
   // leading zero: this digit and all above are zero, lsd always shown
   always_comb begin
      nz = 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (i >= int'(digit_q) && latch_q[i*4 +: 4] != 4'h0) begin
            nz = 1'b1;
         end
      end
   end
   assign blank = tri_lv[bucc_pkg::TRI_SEG].high || state_q == bucc_pkg::ST_OFF
                  || (tri_lv[bucc_pkg::TRI_SEG].open_c && digit_q != bucc_pkg::LSD && !nz);
   bucc_seg_enc u_seg (
      .clk   (SYS_CLK),
      .rst_b (RST_B),
      .digit (latch_q[digit_q*4 +: 4]),
      .blank (blank),
      .seg_q (SEG_O)
   );
   // digit strobes and bcd output, registered with the segments
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         DIGIT_O <= 4'h0;
         BCD_O   <= 4'h0;
         BCD_OE  <= 4'h0;
      end else begin
         DIGIT_O <= (state_q == bucc_pkg::ST_OFF) ? 4'h0 : 4'h1 << digit_q;
         BCD_O   <= latch_q[digit_q*4 +: 4];
         BCD_OE  <= {4{state_q == bucc_pkg::ST_NORM && tri_lv[bucc_pkg::TRI_PRE].open_c
                       && tri_lv[bucc_pkg::TRI_CMP].open_c}};
      end
   end
   // flags, registered; compare is live in every direction
   assign match_now = (cnt_q == cmp_q);
   assign zero_now  = (cnt_q == bucc_pkg::CNT_RST);
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         MATCH_B      <= 1'b1;
         ZERO_B       <= 1'b1;
         match_prev_q <= 1'b1; // count and compare are equal at reset: no false rise
         zero_prev_q  <= 1'b1;
      end else begin
         MATCH_B      <= ~match_now;
         ZERO_B       <= ~zero_now;
         match_prev_q <= match_now;
         zero_prev_q  <= zero_now;
      end
   end
   // events: match and zero conditions becoming true (flags falling) and end of a load sequence
   always_comb begin
      ev                     = 3'h0;
      ev[bucc_pkg::EV_MATCH] = match_now & ~match_prev_q;
      ev[bucc_pkg::EV_ZERO]  = zero_now & ~zero_prev_q;
      ev[bucc_pkg::EV_LOAD]  = state_q == bucc_pkg::ST_LOAD && tick
                               && digit_q == bucc_pkg::LSD && !load_req;
   end
   // status write-one-to-clear; a new event beats the clear
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         status_q <= bucc_pkg::STATUS_RST;
      end else if (WR && ADDR == bucc_pkg::REG_STATUS) begin
         status_q <= (status_q & ~WDATA[2:0]) | ev;
      end else begin
         status_q <= status_q | ev;
      end
   end
   // mask and control writes
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         mask_q    <= bucc_pkg::MASK_RST;
         ext_sel_q <= bucc_pkg::CTRL_RST;
      end else if (WR && ADDR == bucc_pkg::REG_MASK) begin
         mask_q <= WDATA[2:0];
      end else if (WR && ADDR == bucc_pkg::REG_CTRL) begin
         ext_sel_q <= WDATA[bucc_pkg::CTRL_EXT_BIT];
      end
   end
   assign IRQ = |(status_q & mask_q);
   // read data stands one cycle after the strobe, zero elsewhere
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B || !RD) begin
         RDATA <= 32'h0;
      end else begin
         case (ADDR)
            bucc_pkg::REG_STATUS:  RDATA <= {29'h0, status_q};
            bucc_pkg::REG_MASK:    RDATA <= {29'h0, mask_q};
            bucc_pkg::REG_CTRL:    RDATA <= {31'h0, ext_sel_q};
            bucc_pkg::REG_COUNT:   RDATA <= {13'h0, state_q, cnt_q};
            bucc_pkg::REG_COMPARE: RDATA <= {16'h0, cmp_q};
            bucc_pkg::REG_LATCH:   RDATA <= {16'h0, latch_q};
            default:               RDATA <= 32'h0;
         endcase
      end
   end
   // load sequence last digit: a tick on the lsd while loading; load_end_a adds the no-request test
   sequence last_digit_s;
      state_q == bucc_pkg::ST_LOAD && tick && digit_q == bucc_pkg::LSD;
   endsequence
   // sampled reset high in the antecedent skips the last reset edge
   match_flag_a: assert property (
      @(posedge SYS_CLK) disable iff (!RST_B)
      RST_B |=> MATCH_B == ($past(cnt_q) != $past(cmp_q)))
      else $error("match flag does not follow compare");
   zero_flag_a: assert property (
      @(posedge SYS_CLK) disable iff (!RST_B) (cnt_q != 16'h0000) |=> ZERO_B)
      else $error("zero flag low on nonzero count");
   cnt_reset_a: assert property (
      @(posedge SYS_CLK) disable iff (!RST_B) !crst_b_s [*2] |-> cnt_q == 16'h0000)
      else $error("counter not held clear by reset pin");
   latch_hold_a: assert property (
      @(posedge SYS_CLK) disable iff (!RST_B) store_s |=> $stable(latch_q))
      else $error("latch changed while store high");
   cmp_keep_a: assert property (
      @(posedge SYS_CLK) disable iff (!RST_B) state_q != bucc_pkg::ST_LOAD |=> $stable(cmp_q))
      else $error("compare register changed outside a load");
   off_mode_a: assert property (
      @(posedge SYS_CLK) disable iff (!RST_B)
      state_q == bucc_pkg::ST_OFF [*2] |-> div_q == '0 && DIGIT_O == 4'h0 && BCD_OE == 4'h0)
      else $error("display off state not quiet");
   load_end_a: assert property (
      @(posedge SYS_CLK) disable iff (!RST_B)
      last_digit_s ##0 !load_req |=> state_q == bucc_pkg::ST_NORM && digit_q == bucc_pkg::MSD)
      else $error("load sequence did not return to normal at msd");
   preset_off_a: assert property (
      @(posedge SYS_CLK) disable iff (!RST_B) tri_lv[bucc_pkg::TRI_PRE].low |=> BCD_OE == 4'h0)
      else $error("bcd port driven with preset load low");
endmodule // bucc_top

// File: verif/bucc_wheel.sv
/*
 thumbwheel switch bank on the bcd port, one decade per digit strobe.
 assumes diode-isolated switches and a pull-down on each bcd line.
*/
`timescale 1ns/1ps
module bucc_wheel (
   // digit strobes from the device
   input  wire logic [3:0]  digit,
   // switch setting, thousands in the top nibble
   input  wire logic [15:0] setting,
   // device side of the bcd port
   input  wire logic [3:0]  dev_bcd,
   input  wire logic [3:0]  dev_oe,
   // resolved port lines
   output logic      [3:0]  bcd
);
   // selected decades wired-or through diodes; pull-down when none strobed
   always_comb begin
      bcd = 4'h0;
      for (int i = 0; i < 4; i++) begin
         if (digit[i]) begin
            bcd = bcd | setting[4*i +: 4];
         end
      end
      // device drive wins, switches sit behind series resistors
      if (dev_oe[0]) begin
         bcd = dev_bcd;
      end
   end
endmodule // bucc_wheel

// File: verif/tb.sv
/*
 self-checking bench for the counter control block with a switch model.
 assumes the register map and scan timing of bucc_pkg.
*/
`timescale 1ns/1ps
module tb;
   // stimulus and observed signals
   logic        sys_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        irq;
   logic        store_b = 1'b1;
   logic        up_dn = 1'b1;
   logic        cnt_rst_b = 1'b1;
   logic        count_in = 1'b0;
   logic [2:0]  tri_hi = 3'h0;
   logic [2:0]  tri_lo = 3'h0;
   logic [3:0]  bcd_i, bcd_o, bcd_oe, digit_o;
   logic [6:0]  seg_o;
   logic        match_b, zero_b;
   logic [15:0] wheel = 16'h0000;
   logic [3:0]  d0;
   int          n_fail = 0;
   int          total_checks = 0;
   int          cycles = 0;

   bucc_top bucc_top_inst (.SYS_CLK(sys_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .TRI_HI(tri_hi), .TRI_LO(tri_lo),
      .STORE_B(store_b), .UP_DN(up_dn), .CNT_RST_B(cnt_rst_b), .COUNT_IN(count_in),
      .SCAN_EXT(1'b0), .BCD_I(bcd_i), .BCD_O(bcd_o), .BCD_OE(bcd_oe), .SEG_O(seg_o),
      .DIGIT_O(digit_o), .MATCH_B(match_b), .ZERO_B(zero_b));

   bucc_wheel bucc_wheel_inst (.digit(digit_o), .setting(wheel), .dev_bcd(bcd_o),
      .dev_oe(bcd_oe), .bcd(bcd_i));

   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;

   // hang guard, well above the few thousand cycles the run needs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         n_fail++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one-cycle strobes, no wait state from the slave
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd_reg(a, d);
      check(d, exp);
   endtask

   // v: 2'b10 high, 2'b01 low, 2'b00 disconnected
   task automatic pin(input int i, input logic [1:0] v);
      @(posedge sys_clk);
      tri_hi[i] <= v[1];
      tri_lo[i] <= v[0];
   endtask

   // pulses held long enough to pass the two-flop synchroniser
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         count_in <= 1'b1;
         repeat (4) @(posedge sys_clk);
         count_in <= 1'b0;
         repeat (4) @(posedge sys_clk);
      end
   endtask

   // poll the state field until normal, bounded
   task automatic wait_norm();
      logic [31:0] d;
      d = 32'h0;
      for (int k = 0; k < 300 && d[18:16] !== 3'h1; k++) begin
         repeat (8) @(posedge sys_clk);
         rd_reg(bucc_pkg::REG_COUNT, d);
      end
      check(32'(d[18:16]), 32'h1);
   endtask

   task automatic t_reset();
      #1;
      check(32'(zero_b), 32'h0);
      check(32'(match_b), 32'h0);
      rd_chk(bucc_pkg::REG_COUNT, 32'h0001_0000);
      rd_chk(8'hFC, 32'h0);
   endtask

   task automatic t_count();
      pulses(3);
      rd_chk(bucc_pkg::REG_COUNT, 32'h0001_0003);
      check(32'(zero_b), 32'h1);
      up_dn <= 1'b0;
      pulses(4);
      rd_chk(bucc_pkg::REG_COUNT, 32'h0001_9999);
      store_b <= 1'b0;
      repeat (5) @(posedge sys_clk);
      store_b <= 1'b1;
      up_dn   <= 1'b1;
      pulses(1);
      rd_chk(bucc_pkg::REG_COUNT, 32'h0001_0000);
      rd_chk(bucc_pkg::REG_LATCH, 32'h0000_9999);
   endtask

   task automatic t_preset();
      logic [31:0] d;
      wheel = 16'h1234;
      wr_reg(bucc_pkg::REG_CTRL, 32'h1);
      pin(1, 2'b10);
      repeat (1100) @(posedge sys_clk);
      check(32'(bcd_oe), 32'h0);
      rd_chk(bucc_pkg::REG_COUNT, 32'h0002_1234);
      pin(1, 2'b00);
      wait_norm();
      rd_chk(bucc_pkg::REG_COUNT, 32'h0001_1234);
      rd_reg(bucc_pkg::REG_STATUS, d);
      check(32'(d[2]), 32'h1);
      wr_reg(bucc_pkg::REG_STATUS, 32'h7);
      wr_reg(bucc_pkg::REG_CTRL, 32'h0);
   endtask

   task automatic t_compare();
      wheel = 16'h1236;
      pin(0, 2'b10);
      repeat (20) @(posedge sys_clk);
      pin(0, 2'b00);
      wait_norm();
      rd_chk(bucc_pkg::REG_COMPARE, 32'h0000_1236);
      rd_chk(bucc_pkg::REG_COUNT, 32'h0001_1234);
      check(32'(match_b), 32'h1);
      wr_reg(bucc_pkg::REG_MASK, 32'h1);
      wr_reg(bucc_pkg::REG_STATUS, 32'h7);
      pulses(2);
      check(32'(match_b), 32'h0);
      check(32'(irq), 32'h1);
      wr_reg(bucc_pkg::REG_STATUS, 32'h1);
      #1;
      check(32'(irq), 32'h0);
      cnt_rst_b <= 1'b0;
      pulses(1);
      check(32'(zero_b), 32'h0);
      rd_chk(bucc_pkg::REG_COUNT, 32'h0001_0000);
      cnt_rst_b <= 1'b1;
      rd_chk(bucc_pkg::REG_COMPARE, 32'h0000_1236);
      wr_reg(bucc_pkg::REG_MASK, 32'h0);
   endtask

   task automatic t_display();
      repeat (10) @(posedge sys_clk);
      #1;
      d0 = digit_o;
      check(32'(bcd_oe), 32'hF);
      check(32'(bcd_o), 32'h9);
      repeat (250) @(posedge sys_clk);
      #1;
      check(32'(digit_o), (d0 == 4'h1) ? 32'h8 : 32'(d0 >> 1));
      store_b <= 1'b0;
      repeat (5) @(posedge sys_clk);
      store_b <= 1'b1;
      for (int k = 0; k < 1100 && digit_o !== 4'h8; k++) begin
         @(posedge sys_clk);
      end
      repeat (5) @(posedge sys_clk);
      #1;
      check(32'(seg_o), 32'h0);
      pin(2, 2'b01);
      repeat (6) @(posedge sys_clk);
      #1;
      check(32'(seg_o[0] | seg_o[1]), 32'h1);
      pin(2, 2'b10);
      repeat (6) @(posedge sys_clk);
      #1;
      check(32'(seg_o), 32'h0);
      pin(2, 2'b00);
      pin(1, 2'b01);
      repeat (6) @(posedge sys_clk);
      #1;
      check(32'(bcd_oe), 32'h0);
      pin(1, 2'b00);
      pin(0, 2'b01);
      repeat (6) @(posedge sys_clk);
      #1;
      check(32'({digit_o, seg_o, bcd_oe}), 32'h0);
      rd_chk(bucc_pkg::REG_COUNT, 32'h0004_0000);
      pin(0, 2'b00);
      repeat (6) @(posedge sys_clk);
      #1;
      check(32'(digit_o), 32'h8);
   endtask

   // reset, then the scenarios in turn
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge sys_clk);
      t_reset();
      t_count();
      t_preset();
      t_compare();
      t_display();
      end_sim();
   end
endmodule // tb
